// ### logic/aofg_pkg.sv
// Package for the assignable output / frequency generator block.
// Assumes a single 100 MHz clock and the plain register port.
package aofg_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SEC_PER_MIN     = 60;
  // A minute of cycles needs 33 bits; 32 would wrap the modulus
  localparam logic [32:0] CYC_PER_MIN    = 33'(SEC_PER_MIN * 64'(CLK_HZ));
  localparam int unsigned RATE_MAX        = 9999;
  localparam int unsigned RATE_W          = 14;
  localparam int unsigned PHASE_W         = 33;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses, word aligned)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_RATE        = 8'h00;
  localparam logic [7:0] OFS_ACCESS      = 8'h04;
  localparam logic [7:0] OFS_MODE        = 8'h08;
  localparam logic [7:0] OFS_ASSIGN      = 8'h0c;
  localparam logic [7:0] OFS_INVERT      = 8'h10;
  localparam logic [7:0] OFS_OUT_SEL     = 8'h14;
  localparam logic [7:0] OFS_STATUS_MON  = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h20;

  // ---------------------------------------------------------------
  // Reset values and field layouts
  // ---------------------------------------------------------------
  localparam logic [13:0] RATE_RST       = 14'h0000;
  localparam logic [1:0]  ACCESS_RST     = 2'h0;
  localparam logic [7:0]  MASK_RST       = 8'h00;
  localparam logic [1:0]  ACCESS_CODE    = 2'h2;
  localparam logic [1:0]  ACCESS_FREE    = 2'h3;
  localparam int unsigned COND_LO_LIM    = 4;   // weight 16
  localparam int unsigned COND_HI_LIM    = 5;   // weight 32

  // Interrupt status bits
  localparam int unsigned IRQ_PULSE      = 0;
  localparam int unsigned IRQ_ALARM_ON   = 1;
  localparam int unsigned IRQ_REJECT     = 2;
  localparam int unsigned IRQ_W          = 3;

  typedef enum logic [0:0] {
    AOFG_MODE_GEN    = 1'b0,
    AOFG_MODE_ASSIGN = 1'b1
  } aofg_mode_e;

endpackage : aofg_pkg

// ### logic/aofg_cfg_if.sv
// Interface carrying settings from the register file to the
// output-forming modules.
// Assumes all sides run on the same clock.
`timescale 1ns/1ns
interface aofg_cfg_if;
  logic [13:0] rate;
  logic [7:0]  assign_mask;
  logic [7:0]  invert_mask;
  logic        out_nc;
  logic [7:0]  cond;
  logic        gen_pulse;
  logic        gen_level;
  logic        alarm_level;

  modport gen_m (
    input  rate,
    output gen_pulse,
    output gen_level
  );
  modport asg_m (
    input  assign_mask,
    input  invert_mask,
    input  out_nc,
    input  cond,
    output alarm_level
  );
  modport top_m (
    output rate,
    output assign_mask,
    output invert_mask,
    output out_nc,
    output cond,
    input  gen_pulse,
    input  gen_level,
    input  alarm_level
  );
endinterface : aofg_cfg_if

// ### logic/aofg_freq_gen.sv
// Pulse-rate generator: phase accumulator, pulses per minute.
// Assumes rate stays within 0..9999 and one 100 MHz clock.
`timescale 1ns/1ns
module aofg_freq_gen #(
  parameter logic [32:0] MIN_CYC = aofg_pkg::CYC_PER_MIN
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  aofg_cfg_if.gen_m cfg
);
  // Modulus must stay above the largest rate
  localparam logic [32:0] MOD  = MIN_CYC;
  localparam logic [32:0] HALF = MOD >> 1;

  logic [32:0] phase_reg;
  logic [32:0] phase_sum;

  // Each clock adds rate; a wrap of one minute of cycles is one pulse
  assign phase_sum = phase_reg + 33'(cfg.rate);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg     <= 33'h0_0000_0000;
      cfg.gen_pulse <= 1'b0;
    end else if (cfg.rate == 14'h0000) begin
      phase_reg     <= 33'h0_0000_0000;
      cfg.gen_pulse <= 1'b0;
    end else if (phase_sum >= MOD) begin
      phase_reg     <= phase_sum - MOD;
      cfg.gen_pulse <= 1'b1;
    end else begin
      phase_reg     <= phase_sum;
      cfg.gen_pulse <= 1'b0;
    end
  end

  // Square wave, near 50 % duty, zero when stopped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg.gen_level <= 1'b0;
    end else begin
      cfg.gen_level <= (cfg.rate != 14'h0000) &&
                       (phase_sum < HALF) && (phase_sum < MOD);
    end
  end
endmodule : aofg_freq_gen

// ### logic/aofg_assign_out.sv
// Assignable alarm output: invert, mask, OR, polarity.
// Assumes condition bits are synchronous to clk_i.
`timescale 1ns/1ns
module aofg_assign_out (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  aofg_cfg_if.asg_m cfg
);
  logic [7:0] conditioned;
  logic       any_true;

  assign conditioned = cfg.cond ^ cfg.invert_mask;
  assign any_true    = |(conditioned & cfg.assign_mask);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg.alarm_level <= 1'b0;
    end else begin
      cfg.alarm_level <= any_true ^ cfg.out_nc;
    end
  end
endmodule : aofg_assign_out

// ### logic/aofg_top.sv
// Top of the assignable output / frequency generator block.
// Assumes synchronous inputs, one 100 MHz clock, and a register
// master that reads data one cycle after the read strobe.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module aofg_top #(
  // Clock cycles in one minute; a smaller value shortens the period
  parameter logic [32:0] MIN_CYC = aofg_pkg::CYC_PER_MIN
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Front-panel rate edit
  input  wire logic [13:0] panel_rate_i,
  input  wire logic        panel_wr_i,
  // Drive-status condition bits
  input  wire logic [7:0]  drive_status_i,
  // Open-collector output stage
  output logic             out_drive_o,
  output logic             out_oe_o,
  // Own leader input taken from the generator
  output logic             leader_pulse_o,
  output logic             irq_o
);

  // -------------------------------------------------------------
  // Settings
  // -------------------------------------------------------------
  logic [13:0] rate_reg;
  logic [1:0]  access_reg;
  aofg_pkg::aofg_mode_e mode_reg;
  logic [7:0]  assign_reg;
  logic [7:0]  invert_reg;
  logic        out_sel_reg;
  logic [2:0]  irq_mask_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_next;
  logic [7:0]  status_reg;
  logic        alarm_prev_reg;
  logic        panel_ok;
  logic        panel_reject;
  logic        rd_stat;
  logic        wr_rate;
  logic        wr_access;
  logic        wr_mode;
  logic        wr_assign;
  logic        wr_invert;
  logic        wr_out_sel;
  logic        wr_irq_mask;
  logic        mode_is_gen;

  aofg_cfg_if cfg_bus ();

  function automatic logic [13:0] clip_rate(input logic [31:0] v);
    clip_rate = (v > 32'(aofg_pkg::RATE_MAX)) ?
                14'(aofg_pkg::RATE_MAX) : v[13:0];
  endfunction : clip_rate

  // All operands passed in, so continuous assigns see every change
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction : wr_hit

  // -------------------------------------------------------------
  // Write decode
  // -------------------------------------------------------------
  assign wr_rate     = wr_hit(reg_wr_i, reg_addr_i, aofg_pkg::OFS_RATE);
  assign wr_access   = wr_hit(reg_wr_i, reg_addr_i, aofg_pkg::OFS_ACCESS);
  assign wr_mode     = wr_hit(reg_wr_i, reg_addr_i, aofg_pkg::OFS_MODE);
  assign wr_assign   = wr_hit(reg_wr_i, reg_addr_i, aofg_pkg::OFS_ASSIGN);
  assign wr_invert   = wr_hit(reg_wr_i, reg_addr_i, aofg_pkg::OFS_INVERT);
  assign wr_out_sel  = wr_hit(reg_wr_i, reg_addr_i, aofg_pkg::OFS_OUT_SEL);
  assign wr_irq_mask = wr_hit(reg_wr_i, reg_addr_i, aofg_pkg::OFS_IRQ_MASK);

  // -------------------------------------------------------------
  // Front panel and rate
  // -------------------------------------------------------------
  // Panel edits only at code-restricted or unrestricted access
  assign panel_ok = (access_reg == aofg_pkg::ACCESS_CODE) ||
                    (access_reg == aofg_pkg::ACCESS_FREE);
  assign panel_reject = panel_wr_i && !panel_ok;

  // Bus write wins if both arrive in one cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_reg <= aofg_pkg::RATE_RST;
    end else if (wr_rate) begin
      rate_reg <= clip_rate(reg_wdata_i);
    end else if (panel_wr_i && panel_ok) begin
      rate_reg <= clip_rate(32'(panel_rate_i));
    end
  end

  // -------------------------------------------------------------
  // Setting registers
  // -------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      access_reg <= aofg_pkg::ACCESS_RST;
    end else if (wr_access) begin
      access_reg <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= aofg_pkg::AOFG_MODE_GEN;
    end else if (wr_mode) begin
      mode_reg <= aofg_pkg::aofg_mode_e'(reg_wdata_i[0]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      assign_reg <= aofg_pkg::MASK_RST;
    end else if (wr_assign) begin
      assign_reg <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      invert_reg <= aofg_pkg::MASK_RST;
    end else if (wr_invert) begin
      invert_reg <= reg_wdata_i[7:0];
    end
  end

  // Any nonzero value selects normally closed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_sel_reg <= 1'b0;
    end else if (wr_out_sel) begin
      out_sel_reg <= |reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_reg <= 3'h0;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= reg_wdata_i[2:0];
    end
  end

  // Status monitor copy; bit 4 lower limit, bit 5 upper limit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= drive_status_i;
    end
  end

  assign cfg_bus.rate        = rate_reg;
  assign cfg_bus.assign_mask = assign_reg;
  assign cfg_bus.invert_mask = invert_reg;
  assign cfg_bus.out_nc      = out_sel_reg;
  assign cfg_bus.cond        = status_reg;

  // -------------------------------------------------------------
  // Output formers
  // -------------------------------------------------------------
  aofg_freq_gen #(
    .MIN_CYC (MIN_CYC)
  ) i_aofg_freq_gen (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .cfg     (cfg_bus.gen_m)
  );

  aofg_assign_out i_aofg_assign_out (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .cfg     (cfg_bus.asg_m)
  );

  // -------------------------------------------------------------
  // Output stage
  // -------------------------------------------------------------
  assign mode_is_gen = (mode_reg == aofg_pkg::AOFG_MODE_GEN);

  // Single physical output, one source at a time
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_drive_o <= 1'b0;
    end else if (mode_is_gen) begin
      out_drive_o <= cfg_bus.gen_level;
    end else begin
      out_drive_o <= cfg_bus.alarm_level;
    end
  end

  // Open collector: enabled only while sinking
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_oe_o <= 1'b0;
    end else if (mode_is_gen) begin
      out_oe_o <= cfg_bus.gen_level;
    end else begin
      out_oe_o <= cfg_bus.alarm_level;
    end
  end

  // Leader follows own train only in generator mode
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      leader_pulse_o <= 1'b0;
    end else begin
      leader_pulse_o <= cfg_bus.gen_pulse && mode_is_gen;
    end
  end

  // -------------------------------------------------------------
  // Interrupts
  // -------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_prev_reg <= 1'b0;
    end else begin
      alarm_prev_reg <= cfg_bus.alarm_level;
    end
  end

  assign rd_stat = reg_rd_i && (reg_addr_i == aofg_pkg::OFS_IRQ_STATUS);

  // Set wins over the read clear in the same cycle
  always_comb begin
    irq_next = rd_stat ? 3'h0 : irq_stat_reg;
    if (cfg_bus.gen_pulse) begin
      irq_next[aofg_pkg::IRQ_PULSE] = 1'b1;
    end
    if (cfg_bus.alarm_level && !alarm_prev_reg) begin
      irq_next[aofg_pkg::IRQ_ALARM_ON] = 1'b1;
    end
    if (panel_reject) begin
      irq_next[aofg_pkg::IRQ_REJECT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= irq_next;
    end
  end

  // Line follows next status, so it drops with the read clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_next & irq_mask_reg);
    end
  end

  // -------------------------------------------------------------
  // Read port
  // -------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        aofg_pkg::OFS_RATE:       reg_rdata_o <= 32'(rate_reg);
        aofg_pkg::OFS_ACCESS:     reg_rdata_o <= 32'(access_reg);
        aofg_pkg::OFS_MODE:       reg_rdata_o <= 32'(mode_reg);
        aofg_pkg::OFS_ASSIGN:     reg_rdata_o <= 32'(assign_reg);
        aofg_pkg::OFS_INVERT:     reg_rdata_o <= 32'(invert_reg);
        aofg_pkg::OFS_OUT_SEL:    reg_rdata_o <= 32'(out_sel_reg);
        aofg_pkg::OFS_STATUS_MON: reg_rdata_o <= 32'(status_reg);
        aofg_pkg::OFS_IRQ_STATUS: reg_rdata_o <= 32'(irq_stat_reg);
        aofg_pkg::OFS_IRQ_MASK:   reg_rdata_o <= 32'(irq_mask_reg);
        // Unmapped addresses read zero
        default:                  reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule : aofg_top

// ### bench/aofg_chk.sv
// Checker for the assignable output block, bound to aofg_top.
// Assumes one clock and shadows settings from bus writes.
`timescale 1ns/1ns
module aofg_chk (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_rdata_o,
  input  wire logic [13:0] panel_rate_i,
  input  wire logic        panel_wr_i,
  input  wire logic [7:0]  drive_status_i,
  input  wire logic        out_drive_o,
  input  wire logic        out_oe_o,
  input  wire logic        leader_pulse_o,
  input  wire logic        irq_o
);
  // ---------------------------------------------------------------
  // Shadow settings
  // ---------------------------------------------------------------
  logic [7:0] asg_q, inv_q;
  logic [2:0] msk_q, stab_q;
  logic [1:0] acc_q;
  logic       nc_q, md_q, rz_q;

  function automatic logic w(input logic [7:0] a);
    return reg_wr_i && (reg_addr_i == a);
  endfunction : w

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {asg_q, inv_q, msk_q, acc_q, nc_q, md_q} <= '0;
      rz_q <= 1'b1;
    end else begin
      if (w(aofg_pkg::OFS_ASSIGN)) asg_q <= reg_wdata_i[7:0];
      if (w(aofg_pkg::OFS_INVERT)) inv_q <= reg_wdata_i[7:0];
      if (w(aofg_pkg::OFS_IRQ_MASK)) msk_q <= reg_wdata_i[2:0];
      if (w(aofg_pkg::OFS_ACCESS)) acc_q <= reg_wdata_i[1:0];
      if (w(aofg_pkg::OFS_OUT_SEL)) nc_q <= |reg_wdata_i;
      if (w(aofg_pkg::OFS_MODE)) md_q <= reg_wdata_i[0];
      // Bus write wins over a panel edit in the same cycle
      if (w(aofg_pkg::OFS_RATE)) rz_q <= ~|reg_wdata_i;
      else if (panel_wr_i && acc_q[1]) rz_q <= ~|panel_rate_i;
    end
  end

  // Cycles since the last settings change, saturating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) stab_q <= 3'h0;
    else if (reg_wr_i || panel_wr_i) stab_q <= 3'h0;
    else if (stab_q != 3'h7) stab_q <= stab_q + 3'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_rd(a);
    reg_rd_i && (reg_addr_i == a);
  endsequence
  sequence s_reject;
    panel_wr_i && !acc_q[1] && msk_q[2] && !w(aofg_pkg::OFS_IRQ_MASK);
  endsequence

  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000;
  endproperty
  property p_rate_max;
    s_rd(aofg_pkg::OFS_RATE) |=> reg_rdata_o <= 32'h0000_270f;
  endproperty
  property p_oe;
    out_oe_o == out_drive_o;
  endproperty
  property p_asg;
    md_q && stab_q > 3'h3 |-> out_drive_o ==
      ((|(($past(drive_status_i, 3) ^ inv_q) & asg_q)) ^ nc_q);
  endproperty
  property p_gen_idle;
    !md_q && rz_q && stab_q > 3'h3 |-> !out_drive_o && !leader_pulse_o;
  endproperty
  property p_asg_nolead;
    md_q && stab_q > 3'h3 |-> !leader_pulse_o;
  endproperty
  property p_irq_off;
    msk_q == 3'h0 && $past(msk_q) == 3'h0 |-> !irq_o;
  endproperty
  property p_reject;
    s_reject |-> ##[1:2] irq_o;
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  a_rate_max: assert property (p_rate_max) else $error("rate > max");
  a_oe: assert property (p_oe) else $error("oe differs");
  a_asg: assert property (p_asg) else $error("alarm wrong");
  a_gen_idle: assert property (p_gen_idle) else $error("rate 0 out");
  a_asg_nolead: assert property (p_asg_nolead) else $error("lead");
  a_irq_off: assert property (p_irq_off) else $error("irq unmasked");
  a_reject: assert property (p_reject) else $error("no reject irq");
endmodule : aofg_chk

bind aofg_top aofg_chk i_aofg_chk (
  .clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .panel_rate_i, .panel_wr_i, .drive_status_i,
  .out_drive_o, .out_oe_o, .leader_pulse_o, .irq_o
);

// ### bench/aofg_load.sv
// Load on the open-collector output and a follower of the train.
// Assumes outputs come from the block's own clock domain.
`timescale 1ns/1ns
module aofg_load (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        drive_i,
  input  wire logic        oe_i,
  input  wire logic        leader_i,
  output logic             line_o,
  output logic [15:0]      pulses_o
);
  // Pull-up holds the line high unless the transistor sinks
  assign line_o = (oe_i && drive_i) ? 1'b0 : 1'b1;
  // Unit follows its own generated train
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pulses_o <= 16'h0000;
    else if (leader_i) pulses_o <= pulses_o + 16'h0001;
  end
endmodule : aofg_load

// ### bench/aofg_test.sv
// Testbench for aofg_top: register tasks, panel and status stimulus.
// Assumes the load model and the bound checker.
`timescale 1ns/1ns
module aofg_test;
  typedef struct {logic [7:0] a, n; logic c; logic [7:0] s;
                  logic e;} aofg_case_s;
  logic        clk_i = 1'b0, rst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00, drive_status_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o;
  logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, panel_wr_i = 1'b0;
  logic [13:0] panel_rate_i = 14'h0000;
  logic        out_drive_o, out_oe_o, leader_pulse_o, irq_o, line;
  logic [15:0] pulses, p0;
  int          n_errors = 0, checks = 0, cycles = 0;
  logic [7:0]  ofs [9] = '{aofg_pkg::OFS_RATE, aofg_pkg::OFS_ACCESS,
    aofg_pkg::OFS_MODE, aofg_pkg::OFS_ASSIGN, aofg_pkg::OFS_INVERT,
    aofg_pkg::OFS_OUT_SEL, aofg_pkg::OFS_STATUS_MON,
    aofg_pkg::OFS_IRQ_MASK, 8'hfc};
  aofg_case_s  tc [8] = '{'{8'h01, 8'h00, 1'b0, 8'h01, 1'b1},
    '{8'h30, 8'h00, 1'b0, 8'h10, 1'b1}, '{8'h30, 8'h00, 1'b0, 8'h20, 1'b1},
    '{8'h30, 8'h00, 1'b0, 8'hcf, 1'b0}, '{8'h01, 8'h01, 1'b0, 8'h00, 1'b1},
    '{8'h01, 8'h01, 1'b0, 8'h01, 1'b0}, '{8'h00, 8'h00, 1'b1, 8'hff, 1'b1},
    '{8'h30, 8'h00, 1'b1, 8'h10, 1'b0}};

  // Short minute: rate 6000 then gives one pulse per 100 cycles
  aofg_top #(.MIN_CYC(33'h0_0009_27c0)) i_aofg_top (.clk_i, .rst_n_i,
    .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .panel_rate_i, .panel_wr_i,
    .drive_status_i, .out_drive_o, .out_oe_o, .leader_pulse_o, .irq_o);
  aofg_load i_aofg_load (.clk_i, .rst_n_i, .drive_i(out_drive_o),
    .oe_i(out_oe_o), .leader_i(leader_pulse_o), .line_o(line),
    .pulses_o(pulses));

  initial forever #5 clk_i = ~clk_i;

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d errors", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Generous ceiling; the tests need about two thousand cycles
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: timeout", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Each access ends with an idle edge so strobes never retoggle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
    @(posedge clk_i);
  endtask : rd

  task automatic pnl(input logic [13:0] r);
    panel_rate_i <= r;
    panel_wr_i <= 1'b1;
    @(posedge clk_i);
    panel_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : pnl

  // Output settles three cycles after the status bits
  task automatic out_is(input logic e);
    repeat (4) @(posedge clk_i);
    #1 chk(32'(out_drive_o), 32'(e));
    chk(32'(line), 32'(!e));
    @(posedge clk_i);
  endtask : out_is

  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
    $display("Test reset finished");
    wr(aofg_pkg::OFS_RATE, 32'h0000_270f);
    rd(aofg_pkg::OFS_RATE, 32'(aofg_pkg::RATE_MAX));
    wr(aofg_pkg::OFS_RATE, 32'h0000_3fff);
    rd(aofg_pkg::OFS_RATE, 32'(aofg_pkg::RATE_MAX));
    $display("Test rate finished");
    wr(aofg_pkg::OFS_IRQ_MASK, 32'h0000_0004);
    for (int a = 0; a < 4; a++) begin
      wr(aofg_pkg::OFS_RATE, 32'h0000_0000);
      wr(aofg_pkg::OFS_ACCESS, 32'(a));
      pnl(14'h003c + 14'(a));
      #1 chk(32'(irq_o), 32'(a < 2));
      @(posedge clk_i);
      rd(aofg_pkg::OFS_IRQ_STATUS, 32'(a < 2 ? 4 : 0));
      rd(aofg_pkg::OFS_RATE, 32'(a < 2 ? 0 : 60 + a));
    end
    wr(aofg_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    wr(aofg_pkg::OFS_RATE, 32'h0000_0000);
    $display("Test panel finished");
    wr(aofg_pkg::OFS_ASSIGN, 32'h0000_00ff);
    drive_status_i <= 8'hff;
    repeat (200) @(posedge clk_i);
    out_is(1'b0);
    chk(32'(pulses), 32'h0000_0000);
    wr(aofg_pkg::OFS_MODE, 32'h0000_0001);
    out_is(1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(aofg_pkg::OFS_ASSIGN, 32'h0000_0001 << i);
      drive_status_i <= 8'h01 << i;
      out_is(1'b1);
      drive_status_i <= ~(8'h01 << i);
      out_is(1'b0);
    end
    rd(aofg_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    wr(aofg_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    drive_status_i <= 8'h80;
    out_is(1'b1);
    #1 chk(32'(irq_o), 32'h0000_0001);
    @(posedge clk_i);
    rd(aofg_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    #1 chk(32'(irq_o), 32'h0000_0000);
    @(posedge clk_i);
    $display("Test weights finished");
    foreach (tc[k]) begin
      wr(aofg_pkg::OFS_ASSIGN, 32'(tc[k].a));
      wr(aofg_pkg::OFS_INVERT, 32'(tc[k].n));
      wr(aofg_pkg::OFS_OUT_SEL, 32'(tc[k].c));
      drive_status_i <= tc[k].s;
      out_is(tc[k].e);
      rd(aofg_pkg::OFS_STATUS_MON, 32'(tc[k].s));
    end
    chk(32'(pulses), 32'h0000_0000);
    $display("Test cases finished");
    wr(aofg_pkg::OFS_MODE, 32'h0000_0000);
    wr(aofg_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    wr(aofg_pkg::OFS_RATE, 32'h0000_1770);
    repeat (300) @(posedge clk_i);
    #1 chk(32'(irq_o), 32'h0000_0001);
    p0 = pulses;
    repeat (1000) @(posedge clk_i);
    #1 chk(32'(pulses - p0), 32'h0000_000a);
    @(posedge clk_i);
    wr(aofg_pkg::OFS_RATE, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    #1 p0 = pulses;
    repeat (300) @(posedge clk_i);
    #1 chk(32'(pulses - p0), 32'h0000_0000);
    chk(32'(out_drive_o), 32'h0000_0000);
    $display("Test generator finished");
    give_verdict();
  end
endmodule : aofg_test
